// ### src/therm_link_pkg.sv
package therm_link_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned MCLK_PERIOD_NS      = 25;
  localparam int unsigned SCLK_PERIOD_MIN_NS  = 160;
  localparam int unsigned SELECT_SETUP_NS     = 100;
  localparam int unsigned SCLK_HALF_CYCLES    =
    (SCLK_PERIOD_MIN_NS / 2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned SELECT_SETUP_CYCLES =
    (SELECT_SETUP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // frame layout
  localparam int unsigned PHASE_CLOCKS = 16;
  localparam int unsigned FRAME_CLOCKS = 32;
  localparam int unsigned CMD_BITS     = 8;
  localparam int unsigned TEMP_BITS    = 14;
  localparam logic [7:0]  CMD_CONVERT  = 8'h00;
  localparam logic [7:0]  CMD_SHUTDOWN = 8'hFF;
  localparam logic [1:0]  TEMP_FILL    = 2'h3;
  // identification value is arbitrary
  localparam logic [15:0] IDENT_WORD_RESET = 16'h2A5B;
  localparam logic        CONVERTING_RESET = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // host controller registers
  localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
  localparam logic [7:0]  TX_OFFSET         = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET     = 8'h08;
  localparam logic [7:0]  RX_OFFSET         = 8'h0C;
  localparam int unsigned CTRL_COUNT_LSB    = 0;
  localparam int unsigned CTRL_KEEP_BIT     = 8;
  localparam int unsigned STATUS_BUSY_BIT   = 0;
  localparam int unsigned STATUS_SELECT_BIT = 1;
  localparam logic [15:0] TX_RESET          = 16'h0000;

endpackage

// ### src/therm_link_if.sv
`timescale 1ns/1ps
interface therm_link_if;
  logic select_n;
  logic serial_clock_in;
  logic host_data_o;
  logic host_data_oe_n;
  logic dev_data_o;
  logic dev_data_oe_n;
  logic data_line;

  // shared data wire; released line reads high as through a pull-up
  assign data_line = !dev_data_oe_n  ? dev_data_o  :
                     !host_data_oe_n ? host_data_o : 1'b1;

  modport device (
    input  select_n,
    input  serial_clock_in,
    input  data_line,
    output dev_data_o,
    output dev_data_oe_n
  );

  modport host (
    output select_n,
    output serial_clock_in,
    output host_data_o,
    output host_data_oe_n,
    input  data_line
  );
endinterface

// ### src/therm_sensor_port.sv
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// R01 - reset into continuous conversion, defaults loaded
// R02 - temperature invalid before first conversion
// R03 - drive on falling, sample on rising
// R04 - frame is 16 send then 16 receive
// R05 - data line released while select high
// R06 - host lowers select, not on rising clock
// R07 - first bit driven when select falls
// R08 - select high aborts send, releases line
// R09 - result during frame loads after select
// R10 - receive phase samples host bits rising
// R11 - select low at most 32 clocks; the host keep bit holds it low across chained frames
// R12 - last eight received bits form command
// R13 - 00 converts, FF shuts down
// R14 - host sends only 00 or FF; the host controller sends whatever word the TX register holds
// R15 - chained read temp, shutdown, id, convert
// R16 - host waits before trusting temperature
// R17 - temperature in bits 15..2, two's complement
// R18 - two lowest bits always one
// R19 - most significant bit sent first
// R20 - shutdown sends identification word instead
// R21 - identification: five maker bits, device bits
// R22 - reading words only, mode write only
// R23 - other codes or short commands ignored
// R24 - output word loaded at select fall
module therm_sensor_port
  import therm_link_pkg::*;
#(
  parameter logic [15:0] IDENT_WORD = IDENT_WORD_RESET
) (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  therm_link_if.device              link,
  input  wire logic                 conv_done,
  input  wire logic [TEMP_BITS-1:0] conv_result,
  output logic                      convert_enable,
  output logic                      temp_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_SEND = 3'b010,
    PH_RECV = 3'b100
  } phase_type;

  typedef struct packed {
    logic [1:0]           sck_sync;
    logic                 sck_prev;
    logic [1:0]           sel_sync;
    logic                 sel_prev;
    logic [1:0]           din_sync;
    phase_type            phase;
    logic [3:0]           bit_cnt;
    logic [15:0]          shift_out;
    logic [7:0]           shift_in;
    logic [3:0]           rx_cnt;
    logic [TEMP_BITS-1:0] latest;
    logic [TEMP_BITS-1:0] pending;
    logic                 pending_v;
    logic                 valid;
    logic                 converting;
    logic                 sio_o;
    logic                 sio_oe_n;
  } dev_state_type;

  localparam dev_state_type DEV_RESET = '{
    sck_sync:   2'h0,
    sck_prev:   1'b0,
    sel_sync:   2'h3,
    sel_prev:   1'b1,
    din_sync:   2'h3,
    phase:      PH_IDLE,
    bit_cnt:    4'h0,
    shift_out:  16'h0000,
    shift_in:   8'h00,
    rx_cnt:     4'h0,
    latest:     '0,
    pending:    '0,
    pending_v:  1'b0,
    valid:      1'b0,
    converting: CONVERTING_RESET,
    sio_o:      1'b0,
    sio_oe_n:   1'b1
  };

  localparam logic [3:0] LAST_BIT = 4'(PHASE_CLOCKS - 1);
  localparam logic [3:0] CMD_FULL = 4'(CMD_BITS);

  dev_state_type s_q;
  dev_state_type s_d;
  logic          sck_rise;
  logic          sck_fall;
  logic          sel_rise;
  logic          sel_fall;
  logic [15:0]   word;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // unknown codes would reach test modes, which are not built here
  function automatic logic next_mode(input logic cur, input logic [7:0] cmd,
                                     input logic [3:0] got);
    logic r;
    r = cur;
    if (got == CMD_FULL) begin                            // R12
      if (cmd == CMD_CONVERT) begin                       // R13
        r = 1'b1;
      end else if (cmd == CMD_SHUTDOWN) begin             // R13
        r = 1'b0;
      end                                                 // R23
    end                                                   // R23
    return r;
  endfunction

  function automatic logic [15:0] out_word(input logic conv,
                                           input logic [TEMP_BITS-1:0] t);
    logic [15:0] w;
    w = IDENT_WORD;                                       // R20 R21 R22
    if (conv) begin
      w = {t, TEMP_FILL};                                 // R17 R18
    end
    return w;
  endfunction

  assign sck_rise = s_q.sck_sync[1] & !s_q.sck_prev;
  assign sck_fall = !s_q.sck_sync[1] & s_q.sck_prev;
  assign sel_rise = s_q.sel_sync[1] & !s_q.sel_prev;
  assign sel_fall = !s_q.sel_sync[1] & s_q.sel_prev;
  assign word     = out_word(s_q.converting, s_q.latest);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    s_d.sck_sync = {s_q.sck_sync[0], link.serial_clock_in};
    s_d.sel_sync = {s_q.sel_sync[0], link.select_n};
    s_d.din_sync = {s_q.din_sync[0], link.data_line};
    s_d.sck_prev = s_q.sck_sync[1];
    s_d.sel_prev = s_q.sel_sync[1];

    case (s_q.phase)
      PH_IDLE: begin
        if (sel_fall) begin
          s_d.shift_out = word;                           // R24
          s_d.sio_o     = word[15];                       // R07 R19
          s_d.sio_oe_n  = 1'b0;
          s_d.phase     = PH_SEND;
          s_d.bit_cnt   = 4'h0;
          s_d.rx_cnt    = 4'h0;
        end else if (s_q.pending_v) begin
          s_d.latest    = s_q.pending;                    // R09
          s_d.valid     = 1'b1;
          s_d.pending_v = 1'b0;
        end
      end
      PH_SEND: begin
        if (sel_rise) begin
          s_d.phase    = PH_IDLE;                         // R08
          s_d.sio_oe_n = 1'b1;                            // R05
        end else if (sck_rise) begin
          if (s_q.bit_cnt == LAST_BIT) begin
            s_d.phase   = PH_RECV;                        // R04
            s_d.bit_cnt = 4'h0;
          end else begin
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end
        end else if (sck_fall) begin
          if (s_q.sio_oe_n) begin
            // second frame under one select: reload after the mode change
            s_d.shift_out = word;                         // R15
            s_d.sio_o     = word[15];
            s_d.sio_oe_n  = 1'b0;
          end else if (s_q.bit_cnt != 4'h0) begin
            s_d.shift_out = {s_q.shift_out[14:0], 1'b0};  // R03 R19
            s_d.sio_o     = s_q.shift_out[14];
          end
        end
      end
      PH_RECV: begin
        if (sel_rise) begin
          s_d.converting = next_mode(s_q.converting, s_q.shift_in, s_q.rx_cnt); // R12
          s_d.phase      = PH_IDLE;
          s_d.sio_oe_n   = 1'b1;                          // R05
        end else if (sck_fall && !s_q.sio_oe_n) begin
          s_d.sio_oe_n = 1'b1;                            // R10
        end else if (sck_rise) begin
          s_d.shift_in = {s_q.shift_in[6:0], s_q.din_sync[1]}; // R10 R03
          if (s_q.rx_cnt != CMD_FULL) begin
            s_d.rx_cnt = s_q.rx_cnt + 4'h1;
          end
          if (s_q.bit_cnt == LAST_BIT) begin
            s_d.converting = next_mode(s_q.converting, s_d.shift_in,
                                       s_d.rx_cnt);       // R15
            s_d.phase      = PH_SEND;                     // R11
            s_d.bit_cnt    = 4'h0;
            s_d.rx_cnt     = 4'h0;
          end else begin
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end
        end
      end
      default: begin
        s_d.phase    = PH_IDLE;
        s_d.sio_oe_n = 1'b1;
      end
    endcase

    // latest result stays frozen while select is low
    if (conv_done) begin
      if (s_q.phase == PH_IDLE && !sel_fall) begin
        s_d.latest    = conv_result;
        s_d.valid     = 1'b1;                             // R02
        s_d.pending_v = 1'b0;
      end else begin
        s_d.pending   = conv_result;                      // R09
        s_d.pending_v = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= DEV_RESET;                                   // R01
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.dev_data_o    = s_q.sio_o;
  assign link.dev_data_oe_n = s_q.sio_oe_n;               // R05
  assign convert_enable     = s_q.converting;
  assign temp_valid         = s_q.valid;                  // R02

endmodule // therm_sensor_port

// ### src/therm_host_ctrl.sv
`timescale 1ns/1ps
module therm_host_ctrl
  import therm_link_pkg::*;
#(
  parameter int unsigned HALF_CYCLES  = SCLK_HALF_CYCLES,
  parameter int unsigned SETUP_CYCLES = SELECT_SETUP_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  therm_link_if.host       link
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_SETUP = 5'b00010,
    H_HIGH  = 5'b00100,
    H_LOW   = 5'b01000,
    H_HOLD  = 5'b10000
  } hstate_type;

  typedef struct packed {
    hstate_type  st;
    logic [3:0]  tick;
    logic [5:0]  remain;
    logic [5:0]  idx;
    logic        keep;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [1:0]  din_sync;
    logic        sel_n;
    logic        sck;
    logic        d_o;
    logic        d_oe_n;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } host_state_type;

  localparam host_state_type HOST_RESET = '{
    st: H_IDLE, tick: 4'h0, remain: 6'h00, idx: 6'h00, keep: 1'b0,
    tx: TX_RESET, rx: 16'h0000, din_sync: 2'h3, sel_n: 1'b1, sck: 1'b0,
    d_o: 1'b0, d_oe_n: 1'b1, prdata: 32'h0000_0000, pready: 1'b0,
    pslverr: 1'b0
  };

  localparam logic [3:0] HALF_LAST  = 4'(HALF_CYCLES - 1);
  localparam logic [3:0] SETUP_LAST = 4'(SETUP_CYCLES - 1);
  localparam logic [5:0] PHASE_LEN  = 6'(PHASE_CLOCKS);
  localparam logic [5:0] FRAME_LEN  = 6'(FRAME_CLOCKS);

  host_state_type s_q;
  host_state_type s_d;
  logic           busy;
  logic [5:0]     req_count;

  assign busy      = (s_q.st != H_IDLE) && (s_q.st != H_HOLD);
  assign req_count = pwdata[CTRL_COUNT_LSB +: 6];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    s_d.din_sync = {s_q.din_sync[0], link.data_line};
    s_d.pready   = 1'b0;
    s_d.pslverr  = 1'b0;

    // answer is ready in the first access cycle
    if (psel && !penable) begin
      s_d.pready = 1'b1;
      case (paddr)
        CTRL_OFFSET:   s_d.prdata = 32'h0000_0000;
        TX_OFFSET:     s_d.prdata = {16'h0000, s_q.tx};
        RX_OFFSET:     s_d.prdata = {16'h0000, s_q.rx};
        STATUS_OFFSET: begin
          s_d.prdata = 32'h0000_0000;
          s_d.prdata[STATUS_BUSY_BIT]   = busy;
          s_d.prdata[STATUS_SELECT_BIT] = !s_q.sel_n;
        end
        default: begin
          s_d.prdata  = 32'h0000_0000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end

    case (s_q.st)
      H_SETUP: begin
        s_d.tick = s_q.tick + 4'h1;
        if (s_q.tick == SETUP_LAST) begin
          s_d.sck  = 1'b1;
          s_d.idx  = s_q.idx + 6'h01;
          s_d.tick = 4'h0;
          s_d.st   = H_HIGH;
        end
      end
      H_HIGH: begin
        s_d.tick = s_q.tick + 4'h1;
        if (s_q.tick == HALF_LAST) begin
          s_d.tick = 4'h0;
          s_d.sck  = 1'b0;
          if (s_q.idx <= PHASE_LEN) begin
            s_d.rx = {s_q.rx[14:0], s_q.din_sync[1]};     // R03
          end
          s_d.remain = s_q.remain - 6'h01;
          if (s_q.remain == 6'h01) begin
            s_d.d_oe_n = 1'b1;
            s_d.sel_n  = !s_q.keep;                       // R11
            s_d.st     = s_q.keep ? H_HOLD : H_IDLE;      // R15
          end else begin
            s_d.st = H_LOW;
            if (s_q.idx >= PHASE_LEN) begin
              s_d.d_o    = s_q.tx[15];                    // R10 R14
              s_d.tx     = {s_q.tx[14:0], 1'b0};
              s_d.d_oe_n = 1'b0;
            end
          end
        end
      end
      H_LOW: begin
        s_d.tick = s_q.tick + 4'h1;
        if (s_q.tick == HALF_LAST) begin
          s_d.tick = 4'h0;
          s_d.sck  = 1'b1;
          s_d.idx  = s_q.idx + 6'h01;
          s_d.st   = H_HIGH;
        end
      end
      H_IDLE, H_HOLD: begin
        s_d.tick = 4'h0;
      end
      default: begin
        s_d.st    = H_IDLE;
        s_d.sel_n = 1'b1;
      end
    endcase

    if (psel && penable && s_q.pready && pwrite) begin
      if (paddr == TX_OFFSET && !busy) begin
        s_d.tx = pwdata[15:0];
      end
      if (paddr == CTRL_OFFSET && !busy) begin
        s_d.remain = (req_count == 6'h00 || req_count > FRAME_LEN) ? FRAME_LEN
                                                                  : req_count; // R11
        s_d.keep   = pwdata[CTRL_KEEP_BIT];
        s_d.idx    = 6'h00;
        s_d.tick   = 4'h0;
        // each frame starts from a clean word so short reads are not mixed with old bits
        s_d.rx     = 16'h0000;
        // select falls while the clock is low and steady
        s_d.sel_n  = 1'b0;                                // R06
        s_d.st     = (s_q.st == H_HOLD) ? H_LOW : H_SETUP;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= HOST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata               = s_q.prdata;
  assign pready               = s_q.pready;
  assign pslverr              = s_q.pslverr;
  assign link.select_n        = s_q.sel_n;
  assign link.serial_clock_in = s_q.sck;
  assign link.host_data_o     = s_q.d_o;
  assign link.host_data_oe_n  = s_q.d_oe_n;

endmodule // therm_host_ctrl

// ### verif/therm_link_checker.sv
`timescale 1ns/1ps
module therm_link_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic select_n,
  input wire logic serial_clock_in,
  input wire logic host_data_o,
  input wire logic host_data_oe_n,
  input wire logic dev_data_o,
  input wire logic dev_data_oe_n,
  input wire logic data_line
);
  logic [5:0] rise_cnt_q;
  logic       clk_dly_q;

  ////////////////////////////////////////////////////////////////////////////
  // rises seen in the frame; wraps after 32 so kept-low chains restart
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rise_cnt_q <= 6'h00;
      clk_dly_q  <= 1'b0;
    end else begin
      clk_dly_q <= serial_clock_in;
      if (select_n) begin
        rise_cnt_q <= 6'h00;
      end else if (serial_clock_in && !clk_dly_q) begin
        rise_cnt_q <= (rise_cnt_q == 6'h1F) ? 6'h00 : rise_cnt_q + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  reset_idle_a : assert property ($rose(resetn) |->
    select_n && dev_data_oe_n && !serial_clock_in) else $error("link not idle after reset");
  idle_release_a : assert property (select_n [*5] |-> dev_data_oe_n)
    else $error("data line driven while deselected");
  select_drive_a : assert property ($fell(select_n) |-> ##[1:4] !dev_data_oe_n)
    else $error("first bit not driven after select fall");
  abort_release_a : assert property ($rose(select_n) |-> ##[1:4] dev_data_oe_n)
    else $error("data line not released after select rise");
  select_setup_a : assert property ($fell(select_n) |-> !serial_clock_in [*3])
    else $error("select fell without clock setup time");
  dev_edge_a : assert property (!dev_data_oe_n && $changed(dev_data_o) |->
    !serial_clock_in) else $error("device bit changed while clock high");
  host_edge_a : assert property (!host_data_oe_n && $changed(host_data_o) |->
    !serial_clock_in) else $error("host bit changed while clock high");
  send_phase_a : assert property ($rose(serial_clock_in) && rise_cnt_q < 16 |->
    !dev_data_oe_n) else $error("device not driving in send phase");
  recv_phase_a : assert property ($rose(serial_clock_in) && rise_cnt_q >= 16 |->
    dev_data_oe_n && !host_data_oe_n) else $error("wrong driver in receive phase");
  fill_ones_a : assert property ($rose(serial_clock_in) && rise_cnt_q >= 14
    && rise_cnt_q < 16 |-> data_line) else $error("low fill bit not one");
endmodule // therm_link_checker

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import therm_link_pkg::*;
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        conv_done, convert_enable, temp_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic [13:0] conv_result;
  logic        err;
  int          errors, checks;
  logic [15:0] temps [4] = '{16'hEC03, 16'hFFFF, 16'h0C83, 16'h4B03};

  therm_link_if therm_link_if_inst ();
  therm_host_ctrl therm_host_ctrl_inst (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(therm_link_if_inst));
  therm_sensor_port therm_sensor_port_inst (.mclk(mclk), .resetn(resetn),
    .link(therm_link_if_inst), .conv_done(conv_done), .conv_result(conv_result),
    .convert_enable(convert_enable), .temp_valid(temp_valid));
  therm_link_checker therm_link_checker_inst (.mclk(mclk), .resetn(resetn),
    .select_n(therm_link_if_inst.select_n),
    .serial_clock_in(therm_link_if_inst.serial_clock_in),
    .host_data_o(therm_link_if_inst.host_data_o),
    .host_data_oe_n(therm_link_if_inst.host_data_oe_n),
    .dev_data_o(therm_link_if_inst.dev_data_o),
    .dev_data_oe_n(therm_link_if_inst.dev_data_oe_n),
    .data_line(therm_link_if_inst.data_line));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // entered just after a rising edge; one idle cycle follows each access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    v   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic frame(input logic [15:0] tx, input logic [8:0] ctrl,
                       input logic [15:0] exp, input string name);
    apb(1'b1, TX_OFFSET, {16'h0000, tx});
    apb(1'b1, CTRL_OFFSET, {23'h000000, ctrl});
    do apb(1'b0, STATUS_OFFSET, 32'h0); while (v[STATUS_BUSY_BIT] !== 1'b0);
    apb(1'b0, RX_OFFSET, 32'h0);
    check(name, {16'h0000, exp}, v);
  endtask

  // converter result strobe, one cycle
  task automatic convert(input logic [15:0] word);
    conv_result <= word[15:2];
    conv_done   <= 1'b1;
    @(posedge mclk);
    conv_done   <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // a frame is under 300 cycles; about 15 frames and polls fit well inside
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; conv_done = 1'b0; conv_result = 14'h0000; errors = 0; checks = 0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    check("convert_enable", 32'h1, {31'h0, convert_enable});
    check("temp_valid", 32'h0, {31'h0, temp_valid});
    apb(1'b0, TX_OFFSET, 32'h0);
    check("tx reset", {16'h0000, TX_RESET}, v);
    apb(1'b1, STATUS_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check("status", 32'h0, v);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, v);
    frame(16'h0000, 9'h010, 16'h0003, "before conversion");
    check("temp_valid", 32'h0, {31'h0, temp_valid});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      convert(temps[i]);
      frame(16'h0000, 9'h010, temps[i], "temperature word");
    end
    check("temp_valid", 32'h1, {31'h0, temp_valid});
    frame(16'h0000, 9'h004, 16'h0004, "aborted word");
    $display("test temperature done");
    frame(16'h00A5, 9'h020, 16'h4B03, "other code");
    check("convert_enable", 32'h1, {31'h0, convert_enable});
    frame(16'hFFFF, 9'h014, 16'h4B03, "short command");
    check("convert_enable", 32'h1, {31'h0, convert_enable});
    frame(16'h00FF, 9'h020, 16'h4B03, "shutdown frame");
    check("convert_enable", 32'h0, {31'h0, convert_enable});
    frame(16'h0000, 9'h010, IDENT_WORD_RESET, "ident word");
    frame(16'hFF00, 9'h020, IDENT_WORD_RESET, "convert frame");
    check("convert_enable", 32'h1, {31'h0, convert_enable});
    $display("test mode done");
    apb(1'b1, TX_OFFSET, 32'h0);
    apb(1'b1, CTRL_OFFSET, 32'h20);
    repeat (20) @(posedge mclk);
    convert(16'h0C83);
    do apb(1'b0, STATUS_OFFSET, 32'h0); while (v[STATUS_BUSY_BIT] !== 1'b0);
    apb(1'b0, RX_OFFSET, 32'h0);
    check("word during conversion", 32'h4B03, v);
    frame(16'h0000, 9'h010, 16'h0C83, "word after frame");
    $display("test held result done");
    frame(16'h00FF, 9'h120, 16'h0C83, "chained temperature");
    check("convert_enable", 32'h0, {31'h0, convert_enable});
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check("select kept", 32'h1, {31'h0, v[STATUS_SELECT_BIT]});
    frame(16'h0000, 9'h018, IDENT_WORD_RESET, "chained ident");
    check("convert_enable", 32'h1, {31'h0, convert_enable});
    $display("test chained done");
    finish_test();
  end
endmodule // testbench
